// *** logic/cbc_core.sv ***
// Core end: sequencing of address, access indicators, scan and watch outputs.
// Assumes the system end keeps reset and stretch inputs legal.
`timescale 1ns/10ps
module cbc_core
   import cbc_pkg::*;
(
   input wire logic CLK_SYS, // System clock
   input wire logic NRST, // Sync reset, active low
   cbc_if.core LNK, // Pins to the system end
   input wire logic REQ_VALID, // Access request
   input wire logic REQ_WRITE, // Request is a write
   input wire logic [4:0] MODE, // Current processor mode
   input wire logic TDO_SHIFT, // Serial test data shifting
   input wire logic [CBC_ADDR_W-1:0] WATCH_ADDR, // Watch compare address
   input wire logic [CBC_ADDR_W-1:0] WATCH_MASK, // Bits set are ignored
   input wire logic WATCH_EN, // Watch enable, not used by match
   output logic ABORTED, // Instruction aborted by reset
   output logic BUSY // Access held in a stretch
);
   // ---------------------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------------------
   cbc_state_t state_r, state_nxt;
   logic [CBC_ADDR_W-1:0] addr_r, addr_nxt;
   logic wr_r, priv_r, tdo_r, valid_r, abort_r;
   logic [1:0] div_r;
   logic dbg_r, upd_r, match_r;
   logic busy_r;

   wire in_reset = !LNK.core_reset_low;
   wire stretch = !LNK.access_stretch_low;
   wire test_reset = !LNK.test_logic_reset_low;
   wire accept = !stretch && REQ_VALID;
   wire div_wrap = (div_r == CBC_SCAN_DIV_LAST);
   wire watch_hit = ((addr_r ^ WATCH_ADDR) & ~WATCH_MASK) == '0;
   // Skip the edge on which the debug clock rises, so match never moves with it
   wire match_load = !dbg_r && !div_wrap;

   always_comb begin
      state_nxt = state_r;
      addr_nxt = addr_r;
      if (in_reset) begin
         state_nxt = CBC_ST_RESET;
         addr_nxt = addr_r + CBC_ADDR_STEP; // Natural wrap past the top
      end else begin
         unique case (state_r)
            CBC_ST_RESET: begin
               state_nxt = CBC_ST_RESTART;
               addr_nxt = CBC_RESTART_ADDR;
            end
            CBC_ST_RESTART: state_nxt = stretch ? CBC_ST_STRETCH : CBC_ST_ACCESS;
            CBC_ST_ACCESS: begin
               if (stretch) begin
                  state_nxt = CBC_ST_STRETCH;
               end else if (accept) begin
                  addr_nxt = addr_r + CBC_ADDR_STEP;
               end
            end
            CBC_ST_STRETCH: if (!stretch) state_nxt = CBC_ST_ACCESS;
         endcase
      end
   end

   // Busy is registered from the next state so the output comes from a flop
   wire stretch_nxt = (state_nxt == CBC_ST_STRETCH);

   // All state moves on the one system clock
   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         state_r <= CBC_ST_RESET;
         addr_r <= CBC_RESTART_ADDR;
         busy_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         addr_r <= addr_nxt;
         busy_r <= stretch_nxt;
      end
   end

   // ---------------------------------------------------------------------------
   // Indicators
   // ---------------------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         wr_r <= 1'b0;
         priv_r <= 1'b1;
         tdo_r <= 1'b1;
         valid_r <= 1'b0;
         abort_r <= 1'b0;
      end else begin
         // Held stable during a stretch so memory sees one access
         if (!stretch) wr_r <= REQ_WRITE && REQ_VALID && !in_reset;
         priv_r <= (MODE != CBC_MODE_USER);
         tdo_r <= !(TDO_SHIFT && !test_reset);
         // One cycle per accepted access; a stretch never repeats it
         valid_r <= accept && !in_reset && state_r == CBC_ST_ACCESS;
         abort_r <= in_reset && state_r != CBC_ST_RESET;
      end
   end

   // ---------------------------------------------------------------------------
   // Scan and debug clocks, watch output
   // ---------------------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (!NRST || test_reset) begin
         div_r <= 2'h0;
         dbg_r <= 1'b0;
         upd_r <= 1'b0;
         match_r <= 1'b0;
      end else begin
         div_r <= div_r + 2'h1;
         if (div_wrap) dbg_r <= !dbg_r;
         upd_r <= div_wrap && dbg_r; // One update pulse per debug period
         // Match may move only while debug clock is low
         if (match_load) match_r <= watch_hit;
      end
   end

   assign LNK.write_not_read = wr_r;
   assign LNK.privileged_access_flag = priv_r;
   assign LNK.test_out_drive_low = tdo_r;
   assign LNK.scan_update_clock = upd_r;
   assign LNK.watch0_match_out = match_r;
   assign LNK.debug_clock_out = dbg_r;
   assign LNK.addr = addr_r;
   assign LNK.access_valid = valid_r;
   assign ABORTED = abort_r;
   assign BUSY = busy_r;
endmodule

// *** logic/cbc_if.sv ***
// Pins between the core control end and the system end.
// Both ends run on the same clock, supplied by the testbench.
`timescale 1ns/10ps
interface cbc_if;
   import cbc_pkg::*;
   logic core_reset_low;
   logic access_stretch_low;
   logic test_logic_reset_low;
   logic write_not_read;
   logic privileged_access_flag;
   logic test_out_drive_low;
   logic scan_update_clock;
   logic watch0_match_out;
   logic debug_clock_out;
   logic [CBC_ADDR_W-1:0] addr;
   logic access_valid;

   modport core (
      input core_reset_low, access_stretch_low, test_logic_reset_low,
      output write_not_read, privileged_access_flag, test_out_drive_low,
      output scan_update_clock, watch0_match_out, debug_clock_out, addr, access_valid
   );
   modport sys (
      output core_reset_low, access_stretch_low, test_logic_reset_low,
      input write_not_read, privileged_access_flag, test_out_drive_low,
      input scan_update_clock, watch0_match_out, debug_clock_out, addr, access_valid
   );
endinterface

// *** logic/cbc_pkg.sv ***
// Constants and types shared by the core control-pin end and the system end.
// Assumes one system clock (CLK_SYS, 40 MHz) and synchronous active-low reset.
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
package cbc_pkg;
   localparam int CBC_ADDR_W = 32;
   localparam int CBC_DATA_W = 32;
   localparam logic [CBC_ADDR_W-1:0] CBC_RESTART_ADDR = 32'h0000_0000;
   localparam logic [CBC_ADDR_W-1:0] CBC_ADDR_STEP = 32'h0000_0004;
   localparam int CBC_RESET_MIN_CYC = 2;
   localparam int CBC_RESET_HIGH_CYC = 1;
   localparam logic [1:0] CBC_SCAN_DIV_LAST = 2'h3;
   localparam logic [4:0] CBC_MODE_USER = 5'h10;
   localparam logic [4:0] CBC_MODE_SVC = 5'h13;

   typedef enum logic [3:0] {
      CBC_ST_RESET = 4'b0001,
      CBC_ST_RESTART = 4'b0010,
      CBC_ST_ACCESS = 4'b0100,
      CBC_ST_STRETCH = 4'b1000
   } cbc_state_t;
endpackage

// *** logic/cbc_sys.sv ***
// System end: drives reset, test reset and stretch pins, watches the indicators.
// Assumes the core end samples its inputs on the same clock edge.
`timescale 1ns/10ps
module cbc_sys
   import cbc_pkg::*;
#(
   parameter int RESET_CYC = CBC_RESET_MIN_CYC
)
(
   input wire logic CLK_SYS, // System clock
   input wire logic NRST, // Sync reset, active low
   cbc_if.sys LNK, // Pins to the core end
   input wire logic RESET_REQ, // Pulse: start a core reset
   input wire logic WAIT_REQ, // Level: stretch the access
   input wire logic STRETCH_USED, // Zero ties stretch high
   output logic WR_SEEN, // Last access was a write
   output logic USER_SEEN, // Core in user mode
   output logic MATCH_SEEN // Watch match registered
);
   // ---------------------------------------------------------------------------
   // Reset generation
   // ---------------------------------------------------------------------------
   logic [7:0] rst_cnt_r;
   logic core_rst_r, trst_r, stretch_r, wr_r, user_r, match_r;
   wire rst_active = rst_cnt_r != 8'h00;

   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         rst_cnt_r <= 8'(RESET_CYC);
         core_rst_r <= 1'b0;
         trst_r <= 1'b0; // Test logic reset pulsed with the first reset
      end else begin
         if (RESET_REQ && !rst_active) rst_cnt_r <= 8'(RESET_CYC);
         else if (rst_active) rst_cnt_r <= rst_cnt_r - 8'h01;
         core_rst_r <= !(rst_active || RESET_REQ);
         trst_r <= 1'b1;
      end
   end

   // ---------------------------------------------------------------------------
   // Stretch pin: registered so it only moves at a clock edge, high under reset
   // ---------------------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         stretch_r <= 1'b1;
         wr_r <= 1'b0;
         user_r <= 1'b0;
         match_r <= 1'b0;
      end else begin
         stretch_r <= !(STRETCH_USED && WAIT_REQ && !rst_active && !RESET_REQ);
         if (LNK.access_valid) wr_r <= LNK.write_not_read;
         user_r <= !LNK.privileged_access_flag;
         match_r <= LNK.watch0_match_out;
      end
   end

   assign LNK.core_reset_low = core_rst_r;
   assign LNK.test_logic_reset_low = trst_r;
   assign LNK.access_stretch_low = stretch_r;
   assign WR_SEEN = wr_r;
   assign USER_SEEN = user_r;
   assign MATCH_SEEN = match_r;
endmodule

// *** testbench/cbc_monitor.sv ***
// Concurrent checks on the pins that join the core end and the system end.
// Instantiated once in tb beside the interface; sees plain copies of its signals.
`timescale 1ns/10ps
module cbc_monitor
   import cbc_pkg::*;
(
   input wire logic CLK_SYS, // System clock
   input wire logic NRST, // Sync reset, active low
   input wire logic core_reset_low, // Core reset pin
   input wire logic access_stretch_low, // Stretch pin
   input wire logic test_logic_reset_low, // Test reset pin
   input wire logic write_not_read, // Write indicator
   input wire logic test_out_drive_low, // Test-out drive
   input wire logic scan_update_clock, // Scan update pulse
   input wire logic watch0_match_out, // Watch match
   input wire logic debug_clock_out, // Debug clock
   input wire logic [CBC_ADDR_W-1:0] addr, // Address
   input wire logic access_valid // Access done
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);
   // ---------------------------------------------------------------
   // Pin relations
   // ---------------------------------------------------------------
   property p_restart;
      $rose(core_reset_low) |-> ##[1:2] addr == CBC_RESTART_ADDR;
   endproperty
   a_restart: assert property (p_restart) else $error("no restart at zero");
   property p_hold;
      $fell(core_reset_low) |-> (!core_reset_low && access_stretch_low)[*2];
   endproperty
   a_hold: assert property (p_hold) else $error("reset too short");
   // Past depth two keeps the first cycles after a bench reset out
   property p_walk;
      !core_reset_low && $past(!core_reset_low) && $past(NRST, 2)
         |-> addr == $past(addr) + CBC_ADDR_STEP;
   endproperty
   a_walk: assert property (p_walk) else $error("address not stepping");
   property p_stretch;
      !access_stretch_low && core_reset_low
         |=> !access_valid && $stable(addr) && $stable(write_not_read);
   endproperty
   a_stretch: assert property (p_stretch) else $error("access not held");
   property p_tdo;
      !test_logic_reset_low |=> test_out_drive_low;
   endproperty
   a_tdo: assert property (p_tdo) else $error("test-out driven in test reset");
   property p_match;
      debug_clock_out && test_logic_reset_low |=> $stable(watch0_match_out);
   endproperty
   a_match: assert property (p_match) else $error("match moved, debug clock high");
   property p_match_low;
      $changed(watch0_match_out) |-> !debug_clock_out && $past(!debug_clock_out);
   endproperty
   a_match_low: assert property (p_match_low) else $error("match moved at debug edge");
   property p_dclk;
      $rose(debug_clock_out) |-> debug_clock_out[*4] ##1 !debug_clock_out;
   endproperty
   a_dclk: assert property (p_dclk) else $error("debug clock half period");
   property p_scan;
      scan_update_clock |=> !scan_update_clock[*7] ##1 scan_update_clock;
   endproperty
   a_scan: assert property (p_scan) else $error("scan update spacing");
endmodule

// *** testbench/tb.sv ***
// Self-checking bench: both ends joined through the pin interface.
// Assumes the hand-over timing; a longer core reset makes the address walk visible.
`timescale 1ns/10ps
module tb;
   import cbc_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_write = 1'b0;
   logic tdo_shift = 1'b0, watch_en = 1'b0, reset_req = 1'b0, wait_req = 1'b0;
   logic stretch_used = 1'b0, aborted, busy, wr_seen, user_seen, match_seen, ab;
   logic [4:0] mode = CBC_MODE_SVC;
   logic [CBC_ADDR_W-1:0] watch_addr = 32'h0000_0000, watch_mask = 32'hFFFF_FFFF, base;
   int errors = 0, checked = 0, cycles = 0;
   cbc_if lnk();
   always #12.5 clk = ~clk;
   cbc_core i_cbc_core (.CLK_SYS(clk), .NRST(nrst), .LNK(lnk), .REQ_VALID(req_valid),
      .REQ_WRITE(req_write), .MODE(mode), .TDO_SHIFT(tdo_shift), .WATCH_ADDR(watch_addr),
      .WATCH_MASK(watch_mask), .WATCH_EN(watch_en), .ABORTED(aborted), .BUSY(busy));
   cbc_sys #(.RESET_CYC(6)) i_cbc_sys (.CLK_SYS(clk), .NRST(nrst), .LNK(lnk),
      .RESET_REQ(reset_req), .WAIT_REQ(wait_req), .STRETCH_USED(stretch_used),
      .WR_SEEN(wr_seen), .USER_SEEN(user_seen), .MATCH_SEEN(match_seen));
   cbc_monitor i_mon (.CLK_SYS(clk), .NRST(nrst), .core_reset_low(lnk.core_reset_low),
      .access_stretch_low(lnk.access_stretch_low), .addr(lnk.addr),
      .test_logic_reset_low(lnk.test_logic_reset_low), .write_not_read(lnk.write_not_read),
      .test_out_drive_low(lnk.test_out_drive_low), .scan_update_clock(lnk.scan_update_clock),
      .watch0_match_out(lnk.watch0_match_out), .debug_clock_out(lnk.debug_clock_out),
      .access_valid(lnk.access_valid));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [CBC_ADDR_W:0] got, input logic [CBC_ADDR_W:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic access(input logic wr);
      @(posedge clk);
      req_valid <= 1'b1;
      req_write <= wr;
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
   endtask
   // Bounded wait for the core reset pin to rise, then the restart cycles
   task automatic settle;
      for (int i = 0; i < 40 && lnk.core_reset_low !== 1'b1; i++) tick(1);
      tick(3);
   endtask
   task automatic results;
      $display("Comparisons %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         results();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      settle();
      check(lnk.addr, CBC_RESTART_ADDR);
      check(lnk.test_logic_reset_low, 1'b1);
      base = lnk.addr;
      access(1'b1);
      check({lnk.access_valid, lnk.write_not_read}, 2'h3);
      check(lnk.addr, base + CBC_ADDR_STEP);
      access(1'b0);
      check({lnk.access_valid, lnk.write_not_read}, 2'h2);
      tick(1);
      check(wr_seen, 1'b0);
      @(posedge clk);
      mode <= CBC_MODE_USER;
      tdo_shift <= 1'b1;
      tick(3);
      check({lnk.privileged_access_flag, user_seen}, 2'h1);
      check(lnk.test_out_drive_low, 1'b0);
      @(posedge clk);
      mode <= CBC_MODE_SVC;
      tdo_shift <= 1'b0;
      watch_addr <= lnk.addr;
      watch_mask <= 32'h0000_0000;
      tick(12);
      check({lnk.privileged_access_flag, lnk.test_out_drive_low}, 2'h3);
      check({lnk.watch0_match_out, match_seen}, 2'h3);
      @(posedge clk);
      watch_addr <= ~lnk.addr;
      watch_en <= 1'b1;
      tick(12);
      check(lnk.watch0_match_out, 1'b0);
      @(posedge clk);
      stretch_used <= 1'b1;
      wait_req <= 1'b1;
      tick(3);
      base = lnk.addr;
      access(1'b1);
      check({lnk.access_valid, lnk.addr}, {1'b0, base});
      check(busy, 1'b1);
      @(posedge clk);
      wait_req <= 1'b0;
      tick(3);
      access(1'b1);
      check({lnk.access_valid, lnk.addr}, {1'b1, base + CBC_ADDR_STEP});
      check(busy, 1'b0);
      @(posedge clk);
      stretch_used <= 1'b0;
      wait_req <= 1'b1;
      tick(3);
      check(lnk.access_stretch_low, 1'b1);
      @(posedge clk);
      wait_req <= 1'b0;
      reset_req <= 1'b1;
      @(posedge clk);
      reset_req <= 1'b0;
      ab = 1'b0;
      repeat (3) begin
         tick(1);
         ab = ab | aborted;
      end
      check(ab, 1'b1);
      base = lnk.addr;
      tick(1);
      check(lnk.addr, base + CBC_ADDR_STEP);
      settle();
      check(lnk.addr, CBC_RESTART_ADDR);
      results();
   end
endmodule
